// File: logic/mbh_pkg.sv
// package: shared constants and types for the multiplexed bus host port
package mbh_pkg;
  localparam int unsigned BUS_W  = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DEPTH  = 256;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic       addr_strobe;
    logic       chip_sel_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] bus_in;
  } mbh_pins_t;

  typedef struct packed {
    logic [7:0] bus_out;
    logic       bus_oe;
  } mbh_drive_t;

  typedef enum logic [1:0] {
    MBH_IDLE,
    MBH_READ,
    MBH_WRITE
  } mbh_state_t;
endpackage : mbh_pkg

// File: logic/mbh_port.sv
// multiplexed address/data bus port, device end
//
// Summary of operation
// - an address strobe captures the address even when chip select is high.
// - with chip select high the port neither drives the bus nor writes the register array.
// - the address is taken from the shared lines at the falling edge of the strobe.
// - write strobe low with chip select low stores bus data at the latched address.
// - the bus is driven with the addressed data only while read and select are low.
// - eight shared lines carry address first and data after, over the same pins.
// - when the read strobe rises the port releases the shared lines.
`timescale 1ns/1ns
module mbh_port (
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               addr_strobe,
  input  wire logic               chip_sel_n,
  input  wire logic               rd_n,
  input  wire logic               wr_n,
  input  wire logic [7:0]         shared_bus_lines_i,
  output logic      [7:0]         shared_bus_lines_o,
  output logic                    shared_bus_lines_oe,
  output logic      [7:0]         latched_addr
);
  logic                 rst_meta_q;
  logic                 rst_n_q;
  logic                 strobe_q;
  logic [7:0]           addr_q;
  logic [7:0]           bus_sample_q;
  logic [7:0]           rdata;
  logic                 we;
  mbh_pkg::mbh_state_t  state_q;
  mbh_pkg::mbh_state_t  state_d;
  mbh_pkg::mbh_pins_t   pins;
  mbh_pkg::mbh_drive_t  drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // strobe decodes for the cycle state; the read decode also feeds the bus drive
  function automatic logic read_sel(input mbh_pkg::mbh_pins_t p);
    return !p.rd_n && !p.chip_sel_n;
  endfunction : read_sel

  function automatic logic write_sel(input mbh_pkg::mbh_pins_t p);
    return !p.wr_n && !p.chip_sel_n;
  endfunction : write_sel

  ////////////////////////////////////////////////////////////////////////////
  // pin bundle; pins are taken as synchronous, so a strobe shorter than one
  // clock may be missed
  assign pins = {addr_strobe,
                 chip_sel_n,
                 rd_n,
                 wr_n,
                 shared_bus_lines_i};

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address latch: bus sampled every cycle, so at the falling edge the value
  // kept is the one present in the strobe's last high cycle
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      strobe_q     <= 1'b0;
      bus_sample_q <= mbh_pkg::ADDR_RST;
      addr_q       <= mbh_pkg::ADDR_RST;
    end
    else
    begin
      strobe_q     <= pins.addr_strobe;
      bus_sample_q <= pins.bus_in;
      if (strobe_q && !pins.addr_strobe)
        addr_q <= bus_sample_q;
    end
  end

  assign latched_addr = addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // cycle state
  always_comb
  begin
    state_d = mbh_pkg::MBH_IDLE;
    case (state_q)
      mbh_pkg::MBH_IDLE,
      mbh_pkg::MBH_READ,
      mbh_pkg::MBH_WRITE:
      begin
        if (pins.chip_sel_n)
          state_d = mbh_pkg::MBH_IDLE;
        else if (read_sel(pins))
          state_d = mbh_pkg::MBH_READ;
        else if (write_sel(pins))
          state_d = mbh_pkg::MBH_WRITE;
        else
          state_d = mbh_pkg::MBH_IDLE;
      end
      default: state_d = mbh_pkg::MBH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state_q <= mbh_pkg::MBH_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write: commit at the edge that sees the strobe end, storing the byte sampled
  // at its last low edge, the stable tail; a write cut short by chip select
  // rising is dropped rather than stored half-formed
  assign we = (state_q == mbh_pkg::MBH_WRITE) && pins.wr_n && !pins.chip_sel_n;

  mbh_reg_array u_regs (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_q),
    .we      (we),
    .waddr   (addr_q),
    .wdata   (bus_sample_q),
    .raddr   (addr_q),
    .rdata   (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read drive; data is one clock behind the address, and the registered enable is
  // gated by the live read decode so release follows the strobe at once
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      drive_q.bus_out <= mbh_pkg::DATA_RST;
      drive_q.bus_oe  <= 1'b0;
    end
    else
    begin
      drive_q.bus_out <= rdata;
      drive_q.bus_oe  <= read_sel(pins);
    end
  end

  assign shared_bus_lines_o  = drive_q.bus_out;
  assign shared_bus_lines_oe = drive_q.bus_oe && read_sel(pins);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_q);

  // address path
  addr_capture_a : assert property (
    $fell(addr_strobe) |=> addr_q == $past(bus_sample_q))
    else $error("address not taken at strobe fall");

  addr_unsel_a : assert property (
    $fell(addr_strobe) && chip_sel_n |=> addr_q == $past(bus_sample_q))
    else $error("address not latched while unselected");

  addr_hold_a : assert property (
    !$fell(addr_strobe) |=> $stable(addr_q))
    else $error("latched address changed without strobe");

  // bus drive
  no_drive_a : assert property (
    chip_sel_n |-> !shared_bus_lines_oe)
    else $error("bus driven while unselected");

  read_drive_a : assert property (
    (!rd_n && !chip_sel_n) ##1 (!rd_n && !chip_sel_n) |-> shared_bus_lines_oe)
    else $error("read not driven");

  read_release_a : assert property (
    rd_n |-> !shared_bus_lines_oe)
    else $error("bus held after read");

  read_hold_a : assert property (
    shared_bus_lines_oe && $past(shared_bus_lines_oe) |-> $stable(shared_bus_lines_o))
    else $error("read data moved while driven");

  // register writes
  no_write_a : assert property (
    chip_sel_n |-> !we)
    else $error("write while unselected");

  write_store_a : assert property (
    we |-> !$past(wr_n) && !$past(chip_sel_n) && !chip_sel_n)
    else $error("store outside write strobe");

  write_commit_a : assert property (
    $rose(wr_n) && !$past(chip_sel_n) && !chip_sel_n |-> we)
    else $error("write strobe ended without a store");

  write_once_a : assert property (
    we |=> !we)
    else $error("one write strobe stored twice");

  read_c    : cover property ((!rd_n && !chip_sel_n) ##1 shared_bus_lines_oe);
  write_c   : cover property (we);
  unsel_c   : cover property ($fell(addr_strobe) && chip_sel_n);
  hold_c    : cover property (shared_bus_lines_oe ##1 shared_bus_lines_oe);
  release_c : cover property (shared_bus_lines_oe ##1 !shared_bus_lines_oe);
endmodule : mbh_port

// File: logic/mbh_reg_array.sv
// register array behind the bus port
`timescale 1ns/1ns
module mbh_reg_array (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem_q [mbh_pkg::DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < mbh_pkg::DEPTH; i++)
        mem_q[i] <= mbh_pkg::DATA_RST;
    end
    else if (we)
      mem_q[waddr] <= wdata;
  end

  assign rdata = mem_q[raddr];
endmodule : mbh_reg_array

// File: tb/mbh_host.sv
// host model: drives address, write and read cycles on the shared lines
`timescale 1ns/1ns
module mbh_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] bus,
  input  wire logic       oe,
  output logic            addr_strobe,
  output logic            chip_sel_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] drv
);
  initial
  begin
    addr_strobe = 1'b0;
    chip_sel_n  = 1'b1;
    rd_n        = 1'b1;
    wr_n        = 1'b1;
    drv         = 8'h00;
  end
  task automatic tick;
    @(posedge ref_clk) #1;
  endtask : tick
  // released lines show the inverse so a stale value never passes
  task automatic put_addr(input logic [7:0] a);
    tick();
    addr_strobe = 1'b1;
    drv = a;
    tick();
    addr_strobe = 1'b0;
    drv = ~a;
    // the port commits the address at the edge after the fall
    tick();
  endtask : put_addr
  task automatic write(input logic [7:0] d, input logic sel);
    tick();
    chip_sel_n = ~sel;
    wr_n = 1'b0;
    drv = d;
    tick();
    tick();
    wr_n = 1'b1;
    tick();
    chip_sel_n = 1'b1;
    drv = ~d;
  endtask : write
  task automatic read(input logic sel, output logic [7:0] d, output logic oe_on,
                      output logic oe_off);
    tick();
    chip_sel_n = ~sel;
    rd_n = 1'b0;
    drv = ~drv;
    tick();
    tick();
    tick();
    d = bus;
    oe_on = oe;
    rd_n = 1'b1;
    #1;
    oe_off = oe;
    tick();
    chip_sel_n = 1'b1;
  endtask : read
endmodule : mbh_host

// File: tb/multiplexed_bus_host_port_tb.sv
// testbench for the multiplexed bus port
`timescale 1ns/1ns
module multiplexed_bus_host_port_tb;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       as, cs_n, rd_n, wr_n, oe;
  logic [7:0] drv, o, la, d;
  logic       on, off;
  int         errors = 0;
  int         checks = 0;
  wire  [7:0] bus = oe ? o : drv;
  always #20 ref_clk = ~ref_clk;
  mbh_host host (.ref_clk(ref_clk), .bus(bus), .oe(oe), .addr_strobe(as),
    .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .drv(drv));
  mbh_port DUT (.ref_clk(ref_clk), .reset_n(reset_n), .addr_strobe(as),
    .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .shared_bus_lines_i(bus),
    .shared_bus_lines_o(o), .shared_bus_lines_oe(oe), .latched_addr(la));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // write then read back over the same eight lines
  task automatic t_write_read(input logic [7:0] a, input logic [7:0] v);
    host.put_addr(a);
    check(la, a);
    host.write(v, 1'b1);
    host.read(1'b1, d, on, off);
    check(d, v);
    check({7'h00, on}, 8'h01);
    check({7'h00, off}, 8'h00);
  endtask : t_write_read
  // deselected cycles latch the address but move no data
  task automatic t_unselected;
    host.put_addr(8'hC3);
    check(la, 8'hC3);
    host.write(8'h3C, 1'b0);
    host.read(1'b0, d, on, off);
    check({7'h00, on}, 8'h00);
    host.read(1'b1, d, on, off);
    check(d, 8'h00);
    check(la, 8'hC3);
  endtask : t_unselected
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    t_write_read(8'h5A, 8'hA5);
    t_write_read(8'h00, 8'hFF);
    t_write_read(8'hFF, 8'h81);
    t_unselected();
    host.put_addr(8'h5A);
    host.read(1'b1, d, on, off);
    check(d, 8'hA5);
    conclude();
  end
  // the whole sequence needs about 76 cycles
  initial
  begin
    #(40 * 2000);
    errors++;
    conclude();
  end
endmodule : multiplexed_bus_host_port_tb
